// ===== design/vosf_pkg.sv
// Constants and types for the output-voltage setpoint and over-voltage register bank
`default_nettype none
package vosf_pkg;
    localparam int CLK_FREQ_KHZ      = 200000;
    localparam int US_PER_MS         = 1000;
    localparam int SLEW_TICK_US      = 1;
    localparam int SLEW_TICK_CYCLES  = CLK_FREQ_KHZ * SLEW_TICK_US / US_PER_MS;
    localparam int RETRY_UNIT_MS     = 35;
    localparam int RETRY_UNIT_CYCLES = RETRY_UNIT_MS * CLK_FREQ_KHZ;
    localparam int TRIM_LIMIT_MV     = 150;
    localparam int MV_PER_V          = 1000;
    localparam int CEIL_PERCENT      = 115;
    localparam int PERCENT_BASE      = 100;
    localparam int FREQ_MIN_KHZ      = 200;
    localparam int FREQ_MAX_KHZ      = 640;
    localparam int PHASE_STEPS       = 256;
    localparam int RAILS_WHEN_ZERO   = 16;
    localparam int MAX_SLEW_SHIFT    = 20;
    localparam int OFFSET_MAX        = 32767;
    localparam int STEP_MAX          = 65535;

    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_SETPOINT     = 8'h21;
    localparam logic [7:0] CMD_TRIM         = 8'h22;
    localparam logic [7:0] CMD_CAL_ADJUST   = 8'h23;
    localparam logic [7:0] CMD_CEILING      = 8'h24;
    localparam logic [7:0] CMD_UPPER_MARGIN = 8'h25;
    localparam logic [7:0] CMD_LOWER_MARGIN = 8'h26;
    localparam logic [7:0] CMD_SLEW_RATE    = 8'h27;
    localparam logic [7:0] CMD_LOAD_LINE    = 8'h28;
    localparam logic [7:0] CMD_SWITCH_RATE  = 8'h33;
    localparam logic [7:0] CMD_PHASE_GROUP  = 8'h37;
    localparam logic [7:0] CMD_OV_THRESHOLD = 8'h40;
    localparam logic [7:0] CMD_OV_REACTION  = 8'h41;

    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] WORD_MAX  = 16'hFFFF;
    localparam logic [7:0]  BYTE_ZERO = 8'h00;

    localparam int RESP_LSB    = 6;
    localparam int RESP_W      = 2;
    localparam int RETRY_LSB   = 3;
    localparam int RETRY_W     = 3;
    localparam int RTIME_LSB   = 0;
    localparam int RTIME_W     = 3;
    localparam int RAILS_LSB   = 4;
    localparam int POS_LSB     = 0;
    localparam int NIBBLE_W    = 4;
    localparam int LIN_EXP_LSB = 11;
    localparam int LIN_EXP_W   = 5;
    localparam int LIN_MANT_W  = 11;

    localparam logic [1:0] RESP_DISABLE_RETRY = 2'h2;
    localparam logic [1:0] MARGIN_LOW_SEL     = 2'h1;
    localparam logic [1:0] MARGIN_HIGH_SEL    = 2'h2;
    localparam logic [2:0] RETRY_NONE         = 3'h0;
    localparam logic [2:0] RETRY_FOREVER      = 3'h7;

    typedef enum logic [1:0] {CMD_READ, CMD_WRITE, CMD_SEND} vosf_kind_type;

    typedef struct packed {
        vosf_kind_type kind;
        logic [7:0]    code;
        logic [15:0]   data;
    } vosf_cmd_type;

    typedef enum logic [1:0] {OV_RUN, OV_WAIT, OV_HOLD} vosf_ov_state_type;

    // Linear word: signed 5-bit exponent over signed 11-bit mantissa
    function automatic int lin_value(logic [15:0] w);
        int e;
        int m;
        e = int'($signed(w[LIN_EXP_LSB +: LIN_EXP_W]));
        m = int'($signed(w[0 +: LIN_MANT_W]));
        return (e >= 0) ? (m <<< e) : (m >>> (-e));
    endfunction
endpackage
`default_nettype wire

// ===== design/vosf_tick_div.sv
// Cycle divider giving a one-cycle enable pulse while running
`default_nettype none
module vosf_tick_div #(
    parameter int CYCLES = 200
) (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic run,
    output logic      tick
);
    localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;

    logic [CW-1:0] count_r;
    wire logic     wrap = (count_r == CW'(CYCLES - 1));

    // Held at zero while idle so every run starts a full period
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= '0;
            tick    <= 1'b0;
        end else if (!run) begin
            count_r <= '0;
            tick    <= 1'b0;
        end else begin
            count_r <= wrap ? '0 : count_r + 1'b1;
            tick    <= wrap;
        end
    end
endmodule
`default_nettype wire

// ===== design/vosf_ramp.sv
// Slew-limited tracker moving a level toward its goal
`default_nettype none
module vosf_ramp #(
    parameter int W = 16
) (
    input  wire logic         clock,
    input  wire logic         reset_n,
    input  wire logic         step_en,
    input  wire logic         follow,
    input  wire logic [W-1:0] goal,
    input  wire logic [W-1:0] step,
    output logic      [W-1:0] level
);
    wire logic         rising  = goal > level;
    wire logic [W-1:0] gap     = rising ? goal - level : level - goal;
    wire logic         overrun = gap <= step;
    wire logic [W-1:0] moved   = rising ? level + step : level - step;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            level <= '0;
        end else if (follow) begin
            level <= goal;
        end else if (step_en && gap != '0) begin
            level <= overrun ? goal : moved;
        end
    end
endmodule
`default_nettype wire

// ===== design/vosf_regs.sv
// Setpoint, trim, margin, frequency, phase_group_config and over-voltage register bank
`default_nettype none
module vosf_regs
    import vosf_pkg::*;
#(
    parameter int RETRY_UNIT_CYC = RETRY_UNIT_CYCLES
) (
    input  wire logic         clock,
    input  wire logic         reset_n,
    input  wire logic         cmd_valid,
    input  wire vosf_cmd_type cmd,
    output logic              rsp_valid,
    output logic              rsp_ack,
    output logic       [15:0] rsp_data,
    input  wire logic  [4:0]  vout_exponent,
    input  wire logic  [15:0] setpoint_strap_pin,
    input  wire logic  [1:0]  margin_select,
    input  wire logic         output_on_request,
    input  wire logic         other_fault_shutdown,
    input  wire logic  [15:0] vout_measured,
    output logic              output_enable,
    output logic       [15:0] vout_target,
    output logic              alert_line_n,
    output logic              ov_fault_status,
    output logic       [9:0]  freq_khz,
    output logic       [7:0]  phase_offset,
    output logic       [15:0] droop_slope
);
    logic [15:0] setpoint_r;
    logic [15:0] trim_r;
    logic [15:0] cal_r;
    logic [15:0] ceiling_r;
    logic [15:0] upper_r;
    logic [15:0] lower_r;
    logic [15:0] slew_r;
    logic [15:0] switch_rate_r;
    logic [7:0]  phase_cfg_r;
    logic [15:0] ov_threshold_r;
    logic [7:0]  reaction_r;
    logic [15:0] strap_r;
    logic        strap_taken_r;
    logic        ov_flag_r;
    logic [2:0]  attempts_r;
    logic [2:0]  attempts_nxt;
    logic        in_retry_r;
    logic        in_retry_nxt;
    logic [2:0]  wait_ticks_r;
    logic [16:0] read_sel;
    vosf_ov_state_type state_r;
    vosf_ov_state_type state_nxt;

    // Offset limit in output LSBs for the current exponent
    function automatic logic signed [15:0] offset_limit(logic [4:0] ve);
        int e;
        int lim;
        e   = int'($signed(ve));
        lim = (e < 0) ? ((TRIM_LIMIT_MV << (-e)) / MV_PER_V) : 0;
        lim = (lim > OFFSET_MAX) ? OFFSET_MAX : lim;
        return 16'(lim);
    endfunction

    function automatic logic [15:0] sat_offset(logic [15:0] d, logic signed [15:0] lim);
        logic signed [15:0] s;
        s = $signed(d);
        if (s > lim) begin
            return lim;
        end
        if (s < -lim) begin
            return -lim;
        end
        return d;
    endfunction

    // Per-microsecond step in output LSBs; never zero so a ramp always ends
    function automatic logic [15:0] slew_step(logic [15:0] rate, logic [4:0] ve);
        int s;
        int m;
        int v;
        s = int'($signed(rate[LIN_EXP_LSB +: LIN_EXP_W])) - int'($signed(ve));
        m = int'($signed(rate[0 +: LIN_MANT_W]));
        m = (m < 0) ? -m : m;
        s = (s > MAX_SLEW_SHIFT) ? MAX_SLEW_SHIFT : s;
        v = (s >= 0) ? (m << s) : (m >> (-s));
        v = v / US_PER_MS;
        v = (v < 1) ? 1 : ((v > STEP_MAX) ? STEP_MAX : v);
        return 16'(v);
    endfunction

    // Command decode
    wire logic is_write = cmd_valid && cmd.kind == CMD_WRITE;
    wire logic is_read  = cmd_valid && cmd.kind == CMD_READ;
    wire logic do_clear = cmd_valid && cmd.kind == CMD_SEND
                          && cmd.code == CMD_CLEAR_FAULTS;
    wire logic wr_setpoint = is_write && cmd.code == CMD_SETPOINT;
    wire logic wr_trim     = is_write && cmd.code == CMD_TRIM;
    wire logic wr_cal      = is_write && cmd.code == CMD_CAL_ADJUST;
    wire logic wr_ceiling  = is_write && cmd.code == CMD_CEILING;
    wire logic wr_upper    = is_write && cmd.code == CMD_UPPER_MARGIN;
    wire logic wr_lower    = is_write && cmd.code == CMD_LOWER_MARGIN;
    wire logic wr_slew     = is_write && cmd.code == CMD_SLEW_RATE;
    wire logic wr_droop    = is_write && cmd.code == CMD_LOAD_LINE;
    wire logic wr_switch   = is_write && cmd.code == CMD_SWITCH_RATE;
    wire logic wr_phase    = is_write && cmd.code == CMD_PHASE_GROUP;
    wire logic wr_ov_thr   = is_write && cmd.code == CMD_OV_THRESHOLD;
    wire logic wr_reaction = is_write && cmd.code == CMD_OV_REACTION;

    wire logic signed [15:0] off_lim = offset_limit(vout_exponent);

    // Ceiling may never pass 115% of the strapped setpoint
    wire logic [31:0] ceil_full  = 32'(strap_r) * CEIL_PERCENT / PERCENT_BASE;
    wire logic [15:0] ceil_limit = (ceil_full[31:16] != '0) ? WORD_MAX : ceil_full[15:0];
    wire logic [15:0] ceil_write = (cmd.data > ceil_limit) ? ceil_limit : cmd.data;

    // Effective target: margin select, offsets, ceiling clamp
    wire logic [15:0] base_target = (margin_select == MARGIN_HIGH_SEL) ? upper_r
                                  : (margin_select == MARGIN_LOW_SEL)  ? lower_r
                                  : setpoint_r;
    wire logic signed [17:0] cmd_sum = $signed({2'b00, base_target})
                                     + 18'($signed(trim_r))
                                     + 18'($signed(cal_r));
    wire logic signed [17:0] ceil_wide = $signed({2'b00, ceiling_r});
    wire logic [15:0] cmd_target = cmd_sum[17] ? WORD_ZERO
                                 : (cmd_sum > ceil_wide) ? ceiling_r
                                 : cmd_sum[15:0];

    wire logic [15:0] step_lsb = slew_step(slew_r, vout_exponent);

    // Frequency decode and range clamp
    wire integer freq_int = lin_value(switch_rate_r);
    wire integer freq_lim = (freq_int < FREQ_MIN_KHZ) ? FREQ_MIN_KHZ
                          : (freq_int > FREQ_MAX_KHZ) ? FREQ_MAX_KHZ : freq_int;

    // Phase offset in 1/256 of a switching period
    wire logic [3:0] rails_field = phase_cfg_r[RAILS_LSB +: NIBBLE_W];
    wire logic [3:0] pos_field   = phase_cfg_r[POS_LSB +: NIBBLE_W];
    wire integer     rails       = (rails_field == '0) ? RAILS_WHEN_ZERO
                                                       : int'(rails_field);
    wire integer     phase_full  = (int'(pos_field) * PHASE_STEPS) / rails;

    // Over-voltage reaction fields
    wire logic [1:0] resp_mode  = reaction_r[RESP_LSB +: RESP_W];
    wire logic [2:0] retry_set  = reaction_r[RETRY_LSB +: RETRY_W];
    wire logic [2:0] retry_time = reaction_r[RTIME_LSB +: RTIME_W];
    wire logic       ov_trip    = vout_measured > ov_threshold_r;
    wire logic       shut_mode  = resp_mode == RESP_DISABLE_RETRY;
    wire logic [2:0] base_att   = in_retry_r ? attempts_r : 3'h0;
    wire logic       may_retry  = retry_set == RETRY_FOREVER
                                  || (retry_set != RETRY_NONE && base_att < retry_set);
    wire logic       stop_req   = !output_on_request || other_fault_shutdown;
    wire logic       retry_tick;
    wire logic       wait_done  = retry_tick && wait_ticks_r == retry_time;
    wire logic       ov_flag_nxt = ov_trip || (ov_flag_r && !do_clear);

    vosf_tick_div #(
        .CYCLES (RETRY_UNIT_CYC)
    ) u_retry_div (
        .clock   (clock),
        .reset_n (reset_n),
        .run     (state_r == OV_WAIT),
        .tick    (retry_tick)
    );

    wire logic slew_tick;

    vosf_tick_div #(
        .CYCLES (SLEW_TICK_CYCLES)
    ) u_slew_div (
        .clock   (clock),
        .reset_n (reset_n),
        .run     (1'b1),
        .tick    (slew_tick)
    );

    // Jumps straight to target while off; ramps only while running
    vosf_ramp #(
        .W (16)
    ) u_ramp (
        .clock   (clock),
        .reset_n (reset_n),
        .step_en (slew_tick),
        .follow  (!output_enable),
        .goal    (cmd_target),
        .step    (step_lsb),
        .level   (vout_target)
    );

    always_comb begin
        state_nxt    = state_r;
        attempts_nxt = attempts_r;
        in_retry_nxt = in_retry_r;
        unique case (state_r)
            OV_RUN: begin
                if (stop_req) begin
                    in_retry_nxt = 1'b0;
                end
                if (output_enable && ov_trip && shut_mode) begin
                    attempts_nxt = base_att;
                    state_nxt    = may_retry ? OV_WAIT : OV_HOLD;
                end
            end
            OV_WAIT: begin
                if (stop_req) begin
                    state_nxt    = OV_RUN;
                    in_retry_nxt = 1'b0;
                end else if (wait_done) begin
                    state_nxt    = OV_RUN;
                    in_retry_nxt = 1'b1;
                    if (retry_set != RETRY_FOREVER) begin
                        attempts_nxt = attempts_r + 3'h1;
                    end
                end
            end
            OV_HOLD: begin
                if (do_clear) begin
                    state_nxt    = OV_RUN;
                    attempts_nxt = 3'h0;
                    in_retry_nxt = 1'b0;
                end
            end
        endcase
    end

    always_comb begin
        unique case (cmd.code)
            CMD_SETPOINT:     read_sel = {1'b1, setpoint_r};
            CMD_TRIM:         read_sel = {1'b1, trim_r};
            CMD_CAL_ADJUST:   read_sel = {1'b1, cal_r};
            CMD_CEILING:      read_sel = {1'b1, ceiling_r};
            CMD_UPPER_MARGIN: read_sel = {1'b1, upper_r};
            CMD_LOWER_MARGIN: read_sel = {1'b1, lower_r};
            CMD_SLEW_RATE:    read_sel = {1'b1, slew_r};
            CMD_LOAD_LINE:    read_sel = {1'b1, droop_slope};
            CMD_SWITCH_RATE:  read_sel = {1'b1, switch_rate_r};
            CMD_PHASE_GROUP:  read_sel = {1'b1, BYTE_ZERO, phase_cfg_r};
            CMD_OV_THRESHOLD: read_sel = {1'b1, ov_threshold_r};
            CMD_OV_REACTION:  read_sel = {1'b1, BYTE_ZERO, reaction_r};
            default:          read_sel = {1'b0, WORD_ZERO};
        endcase
    end

    wire logic mapped = read_sel[16] && (is_read || is_write);

    // Strap is caught once, on the first edge after reset release
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            strap_r       <= WORD_ZERO;
            strap_taken_r <= 1'b0;
        end else if (!strap_taken_r) begin
            strap_r       <= setpoint_strap_pin;
            strap_taken_r <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            setpoint_r     <= WORD_ZERO;
            trim_r         <= WORD_ZERO;
            cal_r          <= WORD_ZERO;
            ceiling_r      <= WORD_ZERO;
            upper_r        <= WORD_ZERO;
            lower_r        <= WORD_ZERO;
            slew_r         <= WORD_ZERO;
            droop_slope    <= WORD_ZERO;
            switch_rate_r  <= WORD_ZERO;
            phase_cfg_r    <= BYTE_ZERO;
            ov_threshold_r <= WORD_MAX;
            reaction_r     <= BYTE_ZERO;
        end else begin
            if (wr_setpoint) setpoint_r <= cmd.data;
            if (wr_trim) trim_r <= sat_offset(cmd.data, off_lim);
            if (wr_cal) cal_r <= sat_offset(cmd.data, off_lim);
            if (wr_ceiling) ceiling_r <= ceil_write;
            if (wr_upper) upper_r <= cmd.data;
            if (wr_lower) lower_r <= cmd.data;
            if (wr_slew) slew_r <= cmd.data;
            if (wr_droop) droop_slope <= cmd.data;
            if (wr_switch) switch_rate_r <= cmd.data;
            if (wr_phase) phase_cfg_r <= cmd.data[7:0];
            if (wr_ov_thr) ov_threshold_r <= cmd.data;
            if (wr_reaction) reaction_r <= cmd.data[7:0];
        end
    end

    // Set wins over a clear arriving in the same cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r         <= OV_RUN;
            attempts_r      <= 3'h0;
            in_retry_r      <= 1'b0;
            ov_flag_r       <= 1'b0;
            ov_fault_status <= 1'b0;
            alert_line_n    <= 1'b1;
            output_enable   <= 1'b0;
        end else begin
            state_r         <= state_nxt;
            attempts_r      <= attempts_nxt;
            in_retry_r      <= in_retry_nxt;
            ov_flag_r       <= ov_flag_nxt;
            ov_fault_status <= ov_flag_nxt;
            alert_line_n    <= !ov_flag_nxt;
            output_enable   <= !stop_req && state_nxt == OV_RUN;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wait_ticks_r <= 3'h0;
        end else if (state_r != OV_WAIT) begin
            wait_ticks_r <= 3'h0;
        end else if (retry_tick) begin
            wait_ticks_r <= wait_ticks_r + 3'h1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            freq_khz     <= 10'(FREQ_MIN_KHZ);
            phase_offset <= BYTE_ZERO;
            rsp_valid    <= 1'b0;
            rsp_ack      <= 1'b0;
            rsp_data     <= WORD_ZERO;
        end else begin
            freq_khz     <= 10'(freq_lim);
            phase_offset <= phase_full[7:0];
            rsp_valid    <= cmd_valid;
            rsp_ack      <= mapped || do_clear;
            rsp_data     <= (is_read && read_sel[16]) ? read_sel[15:0] : WORD_ZERO;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    sequence s_shutdown;
        state_r == OV_RUN && output_enable && ov_trip && shut_mode;
    endsequence

    a_alert_on_trip: assert property (ov_trip |=> !alert_line_n && ov_fault_status)
        else $error("alert not raised on over-voltage");
    a_shutdown_off: assert property (s_shutdown |=> !output_enable)
        else $error("output not disabled on shutdown");
    a_hold_latched: assert property (state_r == OV_HOLD && !do_clear
        |=> state_r == OV_HOLD && !output_enable)
        else $error("latched shutdown left without clear");
    a_forever_retry: assert property ((s_shutdown and retry_set == RETRY_FOREVER)
        |=> state_r == OV_WAIT)
        else $error("continuous retry not taken");
    a_attempt_bound: assert property (state_r == OV_WAIT && retry_set != RETRY_FOREVER
        && $stable(reaction_r) |-> attempts_r < retry_set)
        else $error("retry attempts exceed setting");
    a_clear_flag: assert property (do_clear && !ov_trip |=> !ov_fault_status)
        else $error("clear faults did not clear status");
    a_ceiling_clamp: assert property (cmd_target <= ceiling_r)
        else $error("target above ceiling");
    a_ceiling_limit: assert property (wr_ceiling |=> ceiling_r <= ceil_limit)
        else $error("ceiling above strap limit");
    a_trim_range: assert property (wr_trim |=> $signed(trim_r) <= $past(off_lim)
        && $signed(trim_r) >= -$past(off_lim))
        else $error("trim outside permitted range");
    a_freq_range: assert property (##1 freq_khz >= 10'(FREQ_MIN_KHZ)
        && freq_khz <= 10'(FREQ_MAX_KHZ))
        else $error("frequency outside range");
    a_phase_zero: assert property (pos_field == '0 |=> phase_offset == BYTE_ZERO)
        else $error("position zero gives non-zero phase");
endmodule
`default_nettype wire

// ===== tb/vosf_host.sv
// Host model issuing read, write and send commands on the command port
`default_nettype none
module vosf_host
    import vosf_pkg::*;
(
    input  wire logic         clock,
    output var logic          cmd_valid,
    output var vosf_cmd_type  cmd,
    input  wire logic         rsp_valid,
    input  wire logic         rsp_ack,
    input  wire logic  [15:0] rsp_data
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
    end
    // Idle data inverted so a stale word is never taken as fresh
    task automatic xfer(input vosf_kind_type k, input logic [7:0] c, input logic [15:0] d,
                        output logic ack, output logic [15:0] q);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd <= '{k, c, d};
        @(posedge clock);
        cmd_valid <= 1'b0;
        cmd.data <= ~d;
        #1;
        ack = rsp_valid & rsp_ack;
        q = rsp_data;
    endtask
endmodule
`default_nettype wire

// ===== tb/vosf_regs_tb.sv
// Self-checking bench for the setpoint and over-voltage register bank
`default_nettype none
module vosf_regs_tb
    import vosf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, reset_n, cmd_valid, rsp_valid, rsp_ack, oen, alert_n, ovf, ack, on_req;
    logic [1:0] msel;
    vosf_cmd_type cmd;
    logic [15:0] rsp_data, vmeas, tgt, droop, q;
    logic [9:0] freq;
    logic [7:0] phase;
    int n_errors = 0;
    int compares = 0;
    vosf_host host (.clock(clock), .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid),
                    .rsp_ack(rsp_ack), .rsp_data(rsp_data));
    vosf_regs #(.RETRY_UNIT_CYC(20)) dut (.clock(clock), .reset_n(reset_n),
        .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack),
        .rsp_data(rsp_data), .vout_exponent(5'h17), .setpoint_strap_pin(16'h0100),
        .margin_select(msel), .output_on_request(on_req), .other_fault_shutdown(1'b0),
        .vout_measured(vmeas), .output_enable(oen), .vout_target(tgt),
        .alert_line_n(alert_n), .ov_fault_status(ovf), .freq_khz(freq),
        .phase_offset(phase), .droop_slope(droop));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Two-cycle over-voltage pulse, then n cycles of quiet
    task automatic trip(input int n);
        @(posedge clock) vmeas <= 16'h0300;
        cyc(1);
        @(posedge clock) vmeas <= 16'h0000;
        cyc(n);
    endtask
    task automatic rw(input logic [7:0] c, input logic [15:0] d, input logic [15:0] e);
        host.xfer(CMD_WRITE, c, d, ack, q);
        check($sformatf("ack %h", c), 16'h0001, {15'h0, ack});
        host.xfer(CMD_READ, c, 16'h0000, ack, q);
        check($sformatf("reg %h", c), e, q);
    endtask
    task automatic t_regs;
        host.xfer(CMD_READ, CMD_OV_THRESHOLD, 16'h0000, ack, q);
        check("thr", 16'hFFFF, q);
        host.xfer(CMD_READ, 8'h30, 16'h0000, ack, q);
        check("nack", 16'h0000, {15'h0, ack});
        host.xfer(CMD_SEND, 8'h11, 16'h0000, ack, q);
        check("send nack", 16'h0000, {15'h0, ack});
        rw(CMD_SETPOINT, 16'h0155, 16'h0155);
        rw(CMD_TRIM, 16'h1000, 16'h004C);
        rw(CMD_CAL_ADJUST, 16'hFF00, 16'hFFB4);
        rw(CMD_CEILING, 16'hFFFF, 16'h0126);
        rw(CMD_SLEW_RATE, 16'h03FF, 16'h03FF);
        rw(CMD_LOAD_LINE, 16'h0010, 16'h0010);
        check("droop", 16'h0010, droop);
        rw(CMD_PHASE_GROUP, 16'hAB32, 16'h0032);
        check("phase", 16'h00AA, {8'h0, phase});
        rw(CMD_PHASE_GROUP, 16'h0004, 16'h0004);
        check("phase", 16'h0040, {8'h0, phase});
        rw(CMD_SWITCH_RATE, 16'h012C, 16'h012C);
        check("freq", 16'd300, {6'h0, freq});
        rw(CMD_SWITCH_RATE, 16'h03E8, 16'h03E8);
        check("freq", 16'd640, {6'h0, freq});
        cyc(450);
        check("target", 16'h0126, tgt);
        $display("register test done");
    endtask
    task automatic t_margin;
        rw(CMD_UPPER_MARGIN, 16'h0100, 16'h0100);
        rw(CMD_LOWER_MARGIN, 16'h0080, 16'h0080);
        @(posedge clock) msel <= MARGIN_HIGH_SEL;
        cyc(250);
        check("margin high", 16'h0100, tgt);
        @(posedge clock) msel <= MARGIN_LOW_SEL;
        cyc(250);
        check("margin low", 16'h0080, tgt);
        @(posedge clock) msel <= 2'h0;
        cyc(250);
        check("nominal", 16'h0126, tgt);
        $display("margin test done");
    endtask
    task automatic t_ov;
        rw(CMD_OV_THRESHOLD, 16'h0200, 16'h0200);
        rw(CMD_OV_REACTION, 16'h0080, 16'h0080);
        check("on", 16'h0001, {15'h0, oen});
        @(posedge clock) vmeas <= 16'h0300;
        cyc(3);
        check("flag", 16'h0001, {15'h0, ovf});
        check("alert", 16'h0000, {15'h0, alert_n});
        check("off", 16'h0000, {15'h0, oen});
        @(posedge clock) vmeas <= 16'h0000;
        cyc(60);
        check("held", 16'h0000, {15'h0, oen});
        host.xfer(CMD_SEND, CMD_CLEAR_FAULTS, 16'h0000, ack, q);
        cyc(5);
        check("clr", 16'h0001, {15'h0, alert_n & ~ovf & oen});
        rw(CMD_OV_REACTION, 16'h0088, 16'h0088);
        trip(10);
        check("wait", 16'h0000, {15'h0, oen});
        cyc(25);
        check("retry", 16'h0001, {15'h0, oen});
        $display("over-voltage test done");
    endtask
    task automatic t_retry;
        rw(CMD_OV_REACTION, 16'h00B8, 16'h00B8);
        trip(30);
        check("retry 1", 16'h0001, {15'h0, oen});
        trip(30);
        check("retry 2", 16'h0001, {15'h0, oen});
        trip(5);
        @(posedge clock) on_req <= 1'b0;
        cyc(30);
        check("stopped", 16'h0000, {15'h0, oen});
        @(posedge clock) on_req <= 1'b1;
        cyc(2);
        check("resumed", 16'h0001, {15'h0, oen});
        rw(CMD_OV_REACTION, 16'h0088, 16'h0088);
        trip(30);
        check("fresh count", 16'h0001, {15'h0, oen});
        trip(30);
        check("spent", 16'h0000, {15'h0, oen});
        host.xfer(CMD_SEND, CMD_CLEAR_FAULTS, 16'h0000, ack, q);
        cyc(2);
        check("cleared", 16'h0001, {15'h0, oen & alert_n});
        $display("retry test done");
    endtask
    task automatic results;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #50us;
        n_errors++;
        results();
    end
    initial begin
        reset_n = 1'b0;
        vmeas = 16'h0000;
        msel = 2'h0;
        on_req = 1'b1;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        cyc(2);
        t_regs();
        t_margin();
        t_ov();
        t_retry();
        results();
    end
endmodule
`default_nettype wire
